//--- shared/ictm_regs.svh
// Purpose: timing constants of the instruction cycle timing block
// Assumes: counts are periods of the external input clock
// Notes: included by ictm_ea_cost and ictm_cycle_timing; definitions only
`ifndef ICTM_REGS_SVH
`define ICTM_REGS_SVH

// ---------------------------------------------------------------
// bus cycle timing
// ---------------------------------------------------------------
`define ICTM_BUS_CLKS 8'h04
`define ICTM_LAST_PHASE 2'h3
`define ICTM_FETCH_CLKS 8'h04
`define ICTM_FETCH_READS 4'h1
`define ICTM_WRITE_COUNT 4'h1
`define ICTM_LONG_EXTRA 8'h04

// ---------------------------------------------------------------
// byte and word address calculation clocks per mode
// ---------------------------------------------------------------
`define ICTM_EA_REG_CLKS 8'h00
`define ICTM_EA_IND_CLKS 8'h04
`define ICTM_EA_PREDEC_CLKS 8'h06
`define ICTM_EA_DISP_CLKS 8'h08
`define ICTM_EA_INDEX_CLKS 8'h0a
`define ICTM_EA_ABSW_CLKS 8'h08
`define ICTM_EA_ABSL_CLKS 8'h0c
`define ICTM_EA_PCDISP_CLKS 8'h08
`define ICTM_EA_PCINDEX_CLKS 8'h0a
`define ICTM_EA_IMM_CLKS 8'h04
`define ICTM_PREDEC_DST_CLKS 8'h00

`endif

//--- shared/ictm_pkg.sv
// Purpose: types of the instruction cycle timing block
// Assumes: constants live in ictm_regs.svh
// Notes: modes, sizes, states and the carried structs
package ictm_pkg;

  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    EA_DREG = 4'h0, EA_AREG = 4'h1, EA_IND = 4'h2, EA_POSTINC = 4'h3,
    EA_PREDEC = 4'h4, EA_DISP = 4'h5, EA_INDEX = 4'h6, EA_ABSW = 4'h7,
    EA_ABSL = 4'h8, EA_PCDISP = 4'h9, EA_PCINDEX = 4'ha, EA_IMM = 4'hb
  } ictm_mode_e;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2
  } ictm_size_e;

  typedef enum logic {
    OP_EA = 1'b0, OP_MOVE = 1'b1
  } ictm_op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_READ = 2'b01, ST_INTERNAL = 2'b10, ST_WRITE = 2'b11
  } ictm_state_e;

  // ---------------------------------------------------------------
  // structs
  // ---------------------------------------------------------------
  typedef struct packed {
    ictm_op_e op;
    ictm_size_e size;
    ictm_mode_e src;
    ictm_mode_e dst;
  } ictm_req_s;

  typedef struct packed {
    logic [7:0] clocks;
    logic [3:0] reads;
    logic [3:0] writes;
  } ictm_cost_s;

  typedef struct packed {
    logic [15:0] total;
    logic [3:0] reads;
    logic [3:0] writes;
    logic [7:0] waits;
  } ictm_res_s;

endpackage : ictm_pkg

//--- design/ictm_pin_sync.sv
// Purpose: two-flop synchronisers for the pins, edge pulse on bit 0
// Assumes: pins are asynchronous to ref_clk
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ps
module ictm_pin_sync (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [1:0] pinIn,
  output logic [1:0] pinSync,
  output logic riseTick
);

  logic [1:0] stage1;
  logic prevBit0;

  // ---------------------------------------------------------------
  // one synchroniser per pin
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      // two stages per pin
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          stage1[gi] <= 1'b0;
          pinSync[gi] <= 1'b0;
        end else begin
          stage1[gi] <= pinIn[gi];
          pinSync[gi] <= stage1[gi];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // rising edge of the synchronised bit 0
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prevBit0 <= 1'b0;
    end else begin
      prevBit0 <= pinSync[0];
    end
  end

  assign riseTick = pinSync[0] & ~prevBit0;

endmodule : ictm_pin_sync

//--- design/ictm_ea_cost.sv
// Purpose: clock and read cost of one address mode, source or destination
// Assumes: destination costs count no operand read, and one write for memory modes only
// Notes: reads follow from clocks, four clocks per read
`timescale 1ns/1ps
`include "ictm_regs.svh"
module ictm_ea_cost (
  input ictm_pkg::ictm_mode_e mode,
  input wire logic isLong,
  input wire logic asDest,
  output ictm_pkg::ictm_cost_s cost,
  output logic invalid
);
  import ictm_pkg::*;

  // ---------------------------------------------------------------
  // byte and word clocks per mode
  // ---------------------------------------------------------------
  function automatic logic [7:0] baseClocks(input ictm_mode_e m);
    logic [7:0] c;
    c = `ICTM_EA_REG_CLKS;
    case (m)
      EA_IND, EA_POSTINC: c = `ICTM_EA_IND_CLKS;
      EA_PREDEC: c = `ICTM_EA_PREDEC_CLKS;
      EA_DISP: c = `ICTM_EA_DISP_CLKS;
      EA_INDEX, EA_PCINDEX: c = `ICTM_EA_INDEX_CLKS;
      EA_ABSW: c = `ICTM_EA_ABSW_CLKS;
      EA_ABSL: c = `ICTM_EA_ABSL_CLKS;
      EA_PCDISP: c = `ICTM_EA_PCDISP_CLKS;
      EA_IMM: c = `ICTM_EA_IMM_CLKS;
      default: c = `ICTM_EA_REG_CLKS;
    endcase
    return c;
  endfunction : baseClocks

  // ---------------------------------------------------------------
  // cost selection
  // ---------------------------------------------------------------
  wire isMem = (mode != EA_DREG) && (mode != EA_AREG);
  wire [7:0] base = baseClocks(mode);
  wire [7:0] srcClocks = base + ((isLong && isMem) ? `ICTM_LONG_EXTRA
                                                   : 8'h00);
  wire [7:0] dstClocks = !isMem ? 8'h00 :
                         (mode == EA_PREDEC) ? `ICTM_PREDEC_DST_CLKS :
                         base - `ICTM_BUS_CLKS;
  wire [7:0] selClocks = asDest ? dstClocks : srcClocks;

  assign cost.clocks = selClocks;
  assign cost.reads = selClocks[5:2];
  assign cost.writes = (asDest && isMem) ? `ICTM_WRITE_COUNT : 4'h0;
  assign invalid = asDest && ((mode == EA_IMM) || (mode == EA_PCDISP) ||
                              (mode == EA_PCINDEX));

endmodule : ictm_ea_cost

//--- design/ictm_cycle_timing.sv
// Purpose: bus cycle sequencer that spends the documented clock counts
// Assumes: ext_clock_in and memAck are pins, synchronised here
// Notes: order is reads, then internal idle periods, then writes
`timescale 1ns/1ps
`include "ictm_regs.svh"
module ictm_cycle_timing (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ext_clock_in,
  input wire logic memAck,
  input wire logic reqValid,
  output logic reqReady,
  input ictm_pkg::ictm_req_s req,
  output logic busRead,
  output logic busWrite,
  output logic busIdle,
  output logic doneValid,
  output logic reqError,
  output ictm_pkg::ictm_res_s result
);
  import ictm_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  ictm_state_e state, next_state;
  logic [1:0] pinSync;
  logic tickS;
  logic [1:0] phase;
  logic [3:0] readsLeft, writesLeft;
  logic [7:0] idleLeft;
  logic [15:0] total;
  logic [7:0] waits;
  ictm_cost_s curCost;
  logic curIsEa;
  ictm_cost_s srcCost, dstCost, reqCost;
  logic srcBad, dstBad;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  ictm_pin_sync u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pinIn({memAck, ext_clock_in}),
    .pinSync(pinSync),
    .riseTick(tickS)
  );
  wire ackS = pinSync[1];

  // ---------------------------------------------------------------
  // source and destination costs
  // ---------------------------------------------------------------
  ictm_ea_cost u_src (
    .mode(req.src),
    .isLong(req.size == SZ_LONG),
    .asDest(1'b0),
    .cost(srcCost),
    .invalid(srcBad)
  );
  ictm_ea_cost u_dst (
    .mode(req.dst),
    .isLong(1'b0),
    .asDest(1'b1),
    .cost(dstCost),
    .invalid(dstBad)
  );

  // ---------------------------------------------------------------
  // request decode
  // ---------------------------------------------------------------
  wire isMove = (req.op == OP_MOVE);
  wire moveBad = isMove && ((req.size == SZ_LONG) || dstBad ||
                 ((req.src == EA_AREG) && (req.size == SZ_BYTE)));
  wire accept = reqValid && (state == ST_IDLE);
  wire acceptOk = accept && !moveBad && !srcBad;
  wire [7:0] moveClocks = `ICTM_FETCH_CLKS + srcCost.clocks +
                          dstCost.clocks +
                          ((dstCost.writes != 4'h0) ? `ICTM_BUS_CLKS
                                                    : 8'h00);
  wire [3:0] moveReads = `ICTM_FETCH_READS + srcCost.reads +
                         dstCost.reads;
  assign reqCost.clocks = isMove ? moveClocks : srcCost.clocks;
  assign reqCost.reads = isMove ? moveReads : srcCost.reads;
  assign reqCost.writes = isMove ? dstCost.writes : 4'h0;
  wire [3:0] busCycles = reqCost.reads + reqCost.writes;
  wire [7:0] idleNew = reqCost.clocks -
                       {2'b00, busCycles, 2'b00};
  assign reqReady = (state == ST_IDLE);

  // ---------------------------------------------------------------
  // bus cycle progress
  // ---------------------------------------------------------------
  wire inBus = (state == ST_READ) || (state == ST_WRITE);
  wire lastPhase = tickS && inBus && (phase == `ICTM_LAST_PHASE);
  wire endCyc = lastPhase && ackS;
  wire addWait = lastPhase && !ackS;
  wire [3:0] next_readsLeft = (state == ST_READ && endCyc) ?
                              readsLeft - 4'h1 : readsLeft;
  wire [3:0] next_writesLeft = (state == ST_WRITE && endCyc) ?
                               writesLeft - 4'h1 : writesLeft;
  wire [7:0] next_idleLeft = (state == ST_INTERNAL && tickS) ?
                             idleLeft - 8'h01 : idleLeft;
  wire [15:0] next_total = total + {15'h0000, tickS};
  wire [7:0] next_waits = waits + {7'h00, addWait};

  // reads first, then idle periods, then writes
  function automatic ictm_state_e pickState(input logic [3:0] r,
                                            input logic [7:0] i,
                                            input logic [3:0] w);
    ictm_state_e s;
    s = ST_IDLE;
    if (r != 4'h0) begin
      s = ST_READ;
    end else if (i != 8'h00) begin
      s = ST_INTERNAL;
    end else if (w != 4'h0) begin
      s = ST_WRITE;
    end
    return s;
  endfunction : pickState

  // ---------------------------------------------------------------
  // state machine
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (acceptOk) begin
          next_state = pickState(reqCost.reads, idleNew, reqCost.writes);
        end
      end
      ST_READ, ST_WRITE: begin
        if (endCyc) begin
          next_state = pickState(next_readsLeft, idleLeft, next_writesLeft);
        end
      end
      ST_INTERNAL: begin
        if (tickS) begin
          next_state = pickState(readsLeft, next_idleLeft, writesLeft);
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end
  wire finish = (next_state == ST_IDLE) &&
                (acceptOk || (state != ST_IDLE));

  // state register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // remaining work counters, loaded at acceptance
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      readsLeft <= 4'h0;
      writesLeft <= 4'h0;
      idleLeft <= 8'h00;
    end else if (acceptOk) begin
      readsLeft <= reqCost.reads;
      writesLeft <= reqCost.writes;
      idleLeft <= idleNew;
    end else begin
      readsLeft <= next_readsLeft;
      writesLeft <= next_writesLeft;
      idleLeft <= next_idleLeft;
    end
  end

  // period within a bus cycle; holds on the last one while waiting
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      phase <= 2'h0;
    end else if (acceptOk || endCyc) begin
      phase <= 2'h0;
    end else if (tickS && inBus && phase != `ICTM_LAST_PHASE) begin
      phase <= phase + 2'h1;
    end
  end

  // elapsed periods and wait states of the running instruction
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      total <= 16'h0000;
      waits <= 8'h00;
      curCost <= '0;
      curIsEa <= 1'b0;
    end else if (acceptOk) begin
      total <= 16'h0000;
      waits <= 8'h00;
      curCost <= reqCost;
      curIsEa <= !isMove;
    end else if (state != ST_IDLE) begin
      total <= next_total;
      waits <= next_waits;
    end
  end

  // completion and refusal reports
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      doneValid <= 1'b0;
      reqError <= 1'b0;
      result <= '0;
    end else begin
      doneValid <= finish;
      reqError <= accept && !acceptOk;
      if (finish) begin
        result.total <= (state == ST_IDLE) ? 16'h0000 : next_total;
        result.reads <= acceptOk ? reqCost.reads : curCost.reads;
        result.writes <= acceptOk ? reqCost.writes : curCost.writes;
        result.waits <= (state == ST_IDLE) ? 8'h00 : next_waits;
      end
    end
  end

  // bus activity decode
  assign busRead = (state == ST_READ);
  assign busWrite = (state == ST_WRITE);
  assign busIdle = (state == ST_INTERNAL);

  // ---------------------------------------------------------------
  // checking helpers
  // ---------------------------------------------------------------
  logic [7:0] cycTicks, cycWaits, idleTicks;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cycTicks <= 8'h00;
      cycWaits <= 8'h00;
    end else if (acceptOk || endCyc) begin
      cycTicks <= 8'h00;
      cycWaits <= 8'h00;
    end else if (tickS && inBus) begin
      cycTicks <= cycTicks + 8'h01;
      cycWaits <= cycWaits + {7'h00, addWait};
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      idleTicks <= 8'h00;
    end else if (acceptOk) begin
      idleTicks <= 8'h00;
    end else if (tickS && state == ST_INTERNAL) begin
      idleTicks <= idleTicks + 8'h01;
    end
  end
  wire [3:0] curCycles = curCost.reads + curCost.writes;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence sAcceptEa(ictm_mode_e m, ictm_size_e s);
    acceptOk && !isMove && req.src == m && req.size == s;
  endsequence
  sequence sAcceptMove(ictm_mode_e ms, ictm_mode_e md);
    acceptOk && isMove && req.src == ms && req.dst == md &&
      req.size == SZ_WORD;
  endsequence

  AST_BUS_FOUR: assert property (@(posedge ref_clk) disable iff (!nrst)
    endCyc |-> cycTicks == 8'h03 + cycWaits)
    else $error("bus cycle length differs from four plus waits");
  AST_TOTAL_WAITS: assert property (@(posedge ref_clk) disable iff (!nrst)
    doneValid |-> result.total ==
      {8'h00, curCost.clocks} + {8'h00, result.waits})
    else $error("total is not cost plus wait states");
  AST_WAIT_COUNT: assert property (@(posedge ref_clk) disable iff (!nrst)
    addWait && !acceptOk |=> waits == $past(waits) + 8'h01)
    else $error("wait state not counted");
  AST_IDLE_SPAN: assert property (@(posedge ref_clk) disable iff (!nrst)
    doneValid |-> idleTicks ==
      curCost.clocks - {2'b00, curCycles, 2'b00})
    else $error("idle periods do not fill the remaining clocks");
  AST_EA_NO_WRITE: assert property (@(posedge ref_clk) disable iff (!nrst)
    curIsEa && state != ST_IDLE |-> !busWrite)
    else $error("address calculation performed a write");
  AST_EA_IND: assert property (@(posedge ref_clk) disable iff (!nrst)
    sAcceptEa(EA_POSTINC, SZ_LONG) |=>
      curCost.clocks == 8'h08 && curCost.reads == 4'h2)
    else $error("postincrement long cost wrong");
  AST_EA_PREDEC: assert property (@(posedge ref_clk) disable iff (!nrst)
    sAcceptEa(EA_PREDEC, SZ_BYTE) |=>
      curCost.clocks == 8'h06 && curCost.reads == 4'h1)
    else $error("predecrement byte cost wrong");
  AST_EA_DISP: assert property (@(posedge ref_clk) disable iff (!nrst)
    sAcceptEa(EA_DISP, SZ_LONG) |=>
      curCost.clocks == 8'h0c && curCost.reads == 4'h3)
    else $error("displacement long cost wrong");
  AST_EA_INDEX: assert property (@(posedge ref_clk) disable iff (!nrst)
    sAcceptEa(EA_PCINDEX, SZ_WORD) |=>
      curCost.clocks == 8'h0a && curCost.reads == 4'h2)
    else $error("indexed word cost wrong");
  AST_MOVE_REG: assert property (@(posedge ref_clk) disable iff (!nrst)
    sAcceptMove(EA_DREG, EA_DREG) |=> curCost.clocks == 8'h04 &&
      curCost.reads == 4'h1 && curCost.writes == 4'h0)
    else $error("register move cost wrong");
  AST_MOVE_MEM: assert property (@(posedge ref_clk) disable iff (!nrst)
    sAcceptMove(EA_IND, EA_DISP) |=> curCost.clocks == 8'h10 &&
      curCost.reads == 4'h3 && curCost.writes == 4'h1)
    else $error("memory move cost wrong");
  AST_AREG_BYTE: assert property (@(posedge ref_clk) disable iff (!nrst)
    accept && isMove && req.src == EA_AREG && req.size == SZ_BYTE
      |=> reqError && state == ST_IDLE)
    else $error("byte move from address register not refused");

endmodule : ictm_cycle_timing

//--- tb/ictm_mem_model.sv
// Purpose: memory side model, makes the input clock and the ready pin
// Assumes: bus flags are looked at mid-period, on the falling input edge
// Notes: waitSet extra periods are added to every read and write cycle
`timescale 1ns/1ps
module ictm_mem_model (
  input wire logic ref_clk,
  input wire logic busRead,
  input wire logic busWrite,
  input wire logic [3:0] waitSet,
  output logic ext_clock_in,
  output logic memAck
);
  logic [3:0] phase;
  logic [4:0] perCnt;
  logic [4:0] next_perCnt;
  logic [4:0] ackAt;

  // free running input clock of sixteen ref_clk periods
  initial begin
    phase = 4'h0;
    perCnt = 5'h00;
    memAck = 1'b1;
  end
  always @(posedge ref_clk) begin
    phase <= phase + 4'h1;
  end
  assign ext_clock_in = phase[3];

  // period count inside one bus cycle; wraps when the cycle completes
  assign ackAt = 5'h04 + {1'b0, waitSet};
  assign next_perCnt = (perCnt == ackAt) ? 5'h01 : perCnt + 5'h01;

  // in a bus cycle ready rises only in the period where the slowed cycle may end; outside bus cycles it is high when waitSet is zero
  always @(negedge ext_clock_in) begin
    if (busRead | busWrite) begin
      perCnt <= next_perCnt;
      memAck <= (next_perCnt >= ackAt);
    end else begin
      perCnt <= 5'h00;
      memAck <= (waitSet == 4'h0);
    end
  end
endmodule : ictm_mem_model

//--- tb/ictm_cycle_timing_bench.sv
// Purpose: self-checking bench of the cycle timing sequencer
// Assumes: one input clock period is sixteen ref_clk periods
// Notes: expected counts are rebuilt here from the mode cost table
`timescale 1ns/1ps
module ictm_cycle_timing_bench;
  import ictm_pkg::*;
  logic ref_clk, nrst, ext_clock_in, memAck, reqValid, reqReady;
  logic busRead, busWrite, busIdle, doneValid, reqError;
  logic [3:0] waitSet;
  ictm_req_s req;
  ictm_res_s result;
  int fail_count, checks_done, cycles, rdF, wrF, idF;
  // byte and word address clocks, indexed by mode
  logic [15:0] bwClk [0:11] = '{16'h0000, 16'h0000, 16'h0004, 16'h0004,
    16'h0006, 16'h0008, 16'h000a, 16'h0008, 16'h000c, 16'h0008, 16'h000a,
    16'h0004};

  ictm_cycle_timing i_dut (.ref_clk(ref_clk), .nrst(nrst),
    .ext_clock_in(ext_clock_in), .memAck(memAck), .reqValid(reqValid),
    .reqReady(reqReady), .req(req), .busRead(busRead), .busWrite(busWrite),
    .busIdle(busIdle), .doneValid(doneValid), .reqError(reqError),
    .result(result));
  ictm_mem_model i_mem (.ref_clk(ref_clk), .busRead(busRead),
    .busWrite(busWrite), .waitSet(waitSet), .ext_clock_in(ext_clock_in),
    .memAck(memAck));

  // clock and run ceiling
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 80000) begin
      fail_count++;
      end_sim();
    end
  end
  // bus periods seen mid-period, by kind
  always @(negedge ext_clock_in) begin
    rdF += busRead;
    wrF += busWrite;
    idF += busIdle;
  end

  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t value %0h expected %0h", $time, got, exp);
    end
  endtask : cmp_val
  task automatic cmp_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : cmp_flag

  // expected totals: fetch, source address, destination reads and write
  function automatic ictm_res_s exp_res(ictm_op_e op, ictm_size_e sz,
    ictm_mode_e s, ictm_mode_e d, logic [3:0] w);
    logic [15:0] c;
    logic [15:0] dc;
    ictm_res_s r;
    c = bwClk[s];
    if (sz == SZ_LONG && s >= EA_IND) c = c + 16'h0004;
    r.reads = c[5:2];
    r.writes = 4'h0;
    if (op == OP_MOVE) begin
      dc = (d == EA_PREDEC) ? 16'h0004 : bwClk[d];
      r.reads = r.reads + 4'h1 + ((d >= EA_IND) ? dc[5:2] - 4'h1 : 4'h0);
      r.writes = (d >= EA_IND) ? 4'h1 : 4'h0;
      c = c + 16'h0004 + dc;
    end
    r.waits = {4'h0, w} * (r.reads + r.writes);
    r.total = c + {8'h00, r.waits};
    return r;
  endfunction : exp_res

  // one request, taken five ref_clk periods after the input rise, judged on result and bus periods
  task automatic run_req(input ictm_op_e op, input ictm_size_e sz,
    input ictm_mode_e s, input ictm_mode_e d, input logic [3:0] w,
    input logic bad);
    ictm_res_s e;
    int n;
    e = exp_res(op, sz, s, d, w);
    waitSet = w;
    @(posedge ext_clock_in);
    repeat (5) @(negedge ref_clk);
    rdF = 0;
    wrF = 0;
    idF = 0;
    req = '{op: op, size: sz, src: s, dst: d};
    reqValid = 1'b1;
    @(negedge ref_clk);
    reqValid = 1'b0;
    // busy after a take unless refused or free of bus and idle periods
    cmp_flag(reqReady, bad || (e.total == 16'h0000));
    n = 0;
    while (doneValid !== 1'b1 && reqError !== 1'b1 && n < 2000) begin
      @(negedge ref_clk);
      n++;
    end
    cmp_flag(n < 2000, 1'b1);
    cmp_flag(reqError, bad);
    if (!bad) begin
      cmp_val(result.total, e.total);
      cmp_val({12'h000, result.reads}, {12'h000, e.reads});
      cmp_val({12'h000, result.writes}, {12'h000, e.writes});
      cmp_val({8'h00, result.waits}, {8'h00, e.waits});
      cmp_val(16'(rdF), 16'((4 + w) * e.reads));
      cmp_val(16'(wrF), 16'((4 + w) * e.writes));
      cmp_val(16'(idF),
        e.total - 16'((4 + w) * (e.reads + e.writes)));
    end
  endtask : run_req

  task automatic t_ea_modes;
    for (int m = 0; m < 12; m++) begin
      for (int z = 0; z < 3; z++) begin
        run_req(OP_EA, ictm_size_e'(z), ictm_mode_e'(m), EA_DREG, 4'h0,
          1'b0);
      end
    end
    $display("test ea_modes done");
  endtask : t_ea_modes

  task automatic t_moves;
    for (int m = 0; m < 12; m++) begin
      run_req(OP_MOVE, SZ_WORD, ictm_mode_e'(m), EA_DREG, 4'h0,
        1'b0);
    end
    for (int m = 0; m < 9; m++) begin
      run_req(OP_MOVE, SZ_BYTE, EA_DISP, ictm_mode_e'(m), 4'h0,
        1'b0);
    end
    run_req(OP_MOVE, SZ_WORD, EA_IND, EA_DISP, 4'h0, 1'b0);
    $display("test moves done");
  endtask : t_moves

  task automatic t_waits;
    run_req(OP_EA, SZ_WORD, EA_IND, EA_DREG, 4'h1, 1'b0);
    run_req(OP_MOVE, SZ_WORD, EA_DISP, EA_ABSL, 4'h2, 1'b0);
    run_req(OP_EA, SZ_LONG, EA_PCINDEX, EA_DREG, 4'h3, 1'b0);
    $display("test waits done");
  endtask : t_waits

  task automatic t_refuse;
    run_req(OP_MOVE, SZ_LONG, EA_DREG, EA_DREG, 4'h0, 1'b1);
    run_req(OP_MOVE, SZ_BYTE, EA_AREG, EA_DREG, 4'h0, 1'b1);
    run_req(OP_MOVE, SZ_WORD, EA_DREG, EA_IMM, 4'h0, 1'b1);
    run_req(OP_MOVE, SZ_WORD, EA_DREG, EA_PCDISP, 4'h0, 1'b1);
    run_req(OP_MOVE, SZ_WORD, EA_DREG, EA_PCINDEX, 4'h0, 1'b1);
    run_req(OP_MOVE, SZ_WORD, EA_AREG, EA_IND, 4'h0, 1'b0);
    $display("test refuse done");
  endtask : t_refuse

  task automatic end_sim;
    $display("checks %0d failures %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  // reset, then the scenarios in turn
  initial begin
    nrst = 1'b0;
    reqValid = 1'b0;
    req = '0;
    waitSet = 4'h0;
    fail_count = 0;
    checks_done = 0;
    cycles = 0;
    repeat (4) @(negedge ref_clk);
    nrst = 1'b1;
    t_ea_modes();
    t_moves();
    t_waits();
    t_refuse();
    end_sim();
  end
endmodule : ictm_cycle_timing_bench
